// ---- vdsc_pkg.sv ----
// Package for the video decoder/scaler configuration bank.
// Assumes byte-indexed registers mapped one per 32-bit AXI4-Lite word.
package vdsc_pkg;
    localparam int NCH = 4;
    // Register indices inside one channel copy (byte address = 4 * index)
    localparam logic [7:0] IDX_PEAK     = 8'h14;
    localparam logic [7:0] IDX_AAF      = 8'h15;
    localparam logic [7:0] IDX_TRAP_X   = 8'h16;
    localparam logic [7:0] IDX_TRAP_Y   = 8'h17;
    localparam logic [7:0] IDX_VR_XH    = 8'h18;
    localparam logic [7:0] IDX_VR_XL    = 8'h19;
    localparam logic [7:0] IDX_VR_YH    = 8'h1a;
    localparam logic [7:0] IDX_VR_YL    = 8'h1b;
    localparam logic [7:0] IDX_HR_XH    = 8'h1c;
    localparam logic [7:0] IDX_HR_XL    = 8'h1d;
    localparam logic [7:0] IDX_HR_YH    = 8'h1e;
    localparam logic [7:0] IDX_HR_YL    = 8'h1f;
    localparam logic [7:0] IDX_VF_X     = 8'h20;
    localparam logic [7:0] IDX_VF_Y     = 8'h21;
    localparam logic [7:0] IDX_BLANK    = 8'h22;
    localparam logic [7:0] IDX_RSVD     = 8'h23;
    localparam logic [7:0] IDX_PB_HDL   = 8'h24;
    localparam logic [7:0] IDX_PB_HAL   = 8'h25;
    localparam logic [7:0] IDX_PB_CTL   = 8'h26;
    localparam logic [7:0] IDX_PB_VDL   = 8'h27;
    localparam logic [7:0] IDX_PB_VAL   = 8'h28;
    // Global registers, channel 0 copy only
    localparam logic [7:0] IDX_PB_F01   = 8'h36;
    localparam logic [7:0] IDX_PB_F23   = 8'h37;
    localparam logic [7:0] IDX_PB_CROP  = 8'h38;
    // Reset values
    localparam logic [7:0] RST_RATIO_B  = 8'hff;
    localparam logic [7:0] RST_VF       = 8'h06;
    localparam logic [7:0] RST_RSVD     = 8'h11;
    localparam logic [7:0] RST_PB_HAL   = 8'hd0;
    localparam logic [7:0] RST_PB_CTL   = 8'h08;
    localparam logic [7:0] RST_PB_VAL   = 8'hf0;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    // Soft reset pulse length
    localparam logic [3:0] SRST_CLKS    = 4'h8;
    localparam int         SRST_BIT     = 3;

    typedef struct packed {
        logic [1:0]  peak_gain;
        logic        peak_band;
        logic [1:0]  vert_aa;
        logic [1:0]  horiz_aa;
        logic        trap_wide;
        logic        comb_force_trap;
        logic        frame_cif_horiz_filter;
        logic [15:0] vert_ratio;
        logic [15:0] horiz_ratio;
        logic        vert_band_reduction_on;
        logic [1:0]  vert_band_reduction;
        logic        odd_en;
        logic        even_en;
    } vdsc_path_s;

    typedef struct packed {
        logic        blank_on;
        logic        blank_black;
        logic        range_narrow;
        logic [7:0]  range_min;
        logic [7:0]  range_max;
    } vdsc_out_s;

    typedef struct packed {
        logic [9:0]  hstart;
        logic [9:0]  hsize;
        logic [8:0]  vstart;
        logic [8:0]  vsize;
        logic [1:0]  vert_aa;
        logic [1:0]  horiz_aa;
    } vdsc_pb_s;

    localparam logic [7:0] RANGE_WIDE_MIN   = 8'h02;
    localparam logic [7:0] RANGE_WIDE_MAX   = 8'hfe;
    localparam logic [7:0] RANGE_NARROW_MIN = 8'h10;
    localparam logic [7:0] RANGE_NARROW_MAX = 8'hef;
endpackage

// ---- vdsc_top.sv ----
// Register bank for eight decoder and four playback paths.
// Assumes an AXI4-Lite master; settings feed the video logic.
// Notes on behaviour
// - Peaking gain codes: none, 31.25, 62.5, 93.75%
// - Vertical AA: full, full, 0.25, 0.18
// - Horizontal AA: full, 2, 1.5, 1 MHz
// - Trap bit selects narrow or wide trap
// - Comb codes 0/1 adaptive, 2 trap
// - Frame CIF special horizontal filter enable
// - Vertical ratio 16 bits, reset ffff
// - Horizontal ratio 16 bits, reset ffff
// - Vertical scaler mode adds band reduction
// - Field enables gate output valid indicator
// - Blank output blue or black
// - Output range 2..254 or 16..239
// - Playback horizontal start, default zero
// - Playback horizontal size, default 720
// - Playback vertical start, default zero
// - Playback vertical size, default 240
// - Own sync off uses decoder windows
// - Own filter off uses decoder filters
// - Packed playback filters at 0x36/0x37
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module vdsc_top (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Decoder window settings, per channel, used when playback follows decoder
    input  wire logic [4*10-1:0]       dec_hstart,
    input  wire logic [4*10-1:0]       dec_hsize,
    input  wire logic [4*9-1:0]        dec_vstart,
    input  wire logic [4*9-1:0]        dec_vsize,
    // Field status and raw valid from the video logic, per channel and path
    input  wire logic [3:0]            field_even,
    input  wire logic [7:0]            valid_raw,
    // Effective settings out
    output vdsc_pkg::vdsc_path_s [7:0] path_cfg,
    output vdsc_pkg::vdsc_out_s  [3:0] out_cfg,
    output vdsc_pkg::vdsc_pb_s   [3:0] pb_cfg,
    output logic [7:0]                 valid_out,
    output logic [3:0]                 video_reset
);
    localparam int NREG = 21;

    // Per-channel register storage, indices 0x14..0x28 packed from zero
    logic [7:0] regs_q [4][NREG];
    logic [7:0] pbf01_q;
    logic [7:0] pbf23_q;
    logic [7:0] crop_q;
    logic [3:0] srst_cnt_q [4];

    // Write channel capture, either order
    logic        aw_have_q;
    logic        w_have_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    function automatic logic [7:0] rst_val(input int i);
        logic [7:0] idx;
        idx = 8'(i) + vdsc_pkg::IDX_PEAK;
        case (idx)
            vdsc_pkg::IDX_VF_X, vdsc_pkg::IDX_VF_Y: rst_val = vdsc_pkg::RST_VF;
            vdsc_pkg::IDX_RSVD:   rst_val = vdsc_pkg::RST_RSVD;
            vdsc_pkg::IDX_PB_HAL: rst_val = vdsc_pkg::RST_PB_HAL;
            vdsc_pkg::IDX_PB_CTL: rst_val = vdsc_pkg::RST_PB_CTL;
            vdsc_pkg::IDX_PB_VAL: rst_val = vdsc_pkg::RST_PB_VAL;
            default: rst_val = (idx >= vdsc_pkg::IDX_VR_XH && idx <= vdsc_pkg::IDX_HR_YL) ?
                               vdsc_pkg::RST_RATIO_B : vdsc_pkg::RST_ZERO;
        endcase
    endfunction

    // Address decode helpers: channel in [9:8], index in [7:2] scaled back
    function automatic logic [7:0] idx_of(input logic [11:0] a);
        idx_of = {2'b00, a[7:2]};
    endfunction

    function automatic logic in_chan(input logic [11:0] a);
        logic [7:0] ix;
        ix = {2'b00, a[7:2]};
        in_chan = (ix >= vdsc_pkg::IDX_PEAK) && (ix <= vdsc_pkg::IDX_PB_VAL) && (a[1:0] == 2'b00);
    endfunction

    logic [1:0]  wr_ch;
    logic [7:0]  wr_ix;
    logic        wr_fire;
    logic        wr_ok;
    logic [7:0]  wr_byte;
    logic [4:0]  wr_slot;
    assign wr_ch   = aw_addr_q[9:8];
    assign wr_ix   = idx_of(aw_addr_q);
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_byte = w_data_q[7:0];
    assign wr_slot = 5'(wr_ix - vdsc_pkg::IDX_PEAK);
    assign wr_ok   = (aw_addr_q[11:10] == 2'b00) && (in_chan(aw_addr_q) ||
                     (wr_ch == 2'b00 && (wr_ix == vdsc_pkg::IDX_PB_F01 || wr_ix == vdsc_pkg::IDX_PB_F23 ||
                                         wr_ix == vdsc_pkg::IDX_PB_CROP)));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= 2'b00;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Per-channel storage and soft reset counters
    for (genvar c = 0; c < 4; c++) begin : g_ch
        logic hit;
        assign hit = wr_fire && wr_ok && w_strb_q[0] && (wr_ch == 2'(c)) && in_chan(aw_addr_q);
        for (genvar r = 0; r < NREG; r++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_q[c][r] <= rst_val(r);
                end else if (hit && wr_slot == 5'(r)) begin
                    regs_q[c][r] <= wr_byte;
                end else if (r == int'(vdsc_pkg::IDX_BLANK - vdsc_pkg::IDX_PEAK) &&
                             srst_cnt_q[c] == 4'h1) begin
                    regs_q[c][r] <= regs_q[c][r] & ~8'(1 << vdsc_pkg::SRST_BIT);
                end
            end
        end
        // Soft reset holds the video logic for a fixed count, then clears the bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                srst_cnt_q[c] <= 4'h0;
            end else if (hit && wr_ix == vdsc_pkg::IDX_BLANK && wr_byte[vdsc_pkg::SRST_BIT]) begin
                srst_cnt_q[c] <= vdsc_pkg::SRST_CLKS;
            end else if (srst_cnt_q[c] != 4'h0) begin
                srst_cnt_q[c] <= srst_cnt_q[c] - 4'h1;
            end
        end
        assign video_reset[c] = (srst_cnt_q[c] != 4'h0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbf01_q <= vdsc_pkg::RST_ZERO;
            pbf23_q <= vdsc_pkg::RST_ZERO;
            crop_q  <= vdsc_pkg::RST_ZERO;
        end else if (wr_fire && wr_ok && w_strb_q[0] && wr_ch == 2'b00) begin
            if (wr_ix == vdsc_pkg::IDX_PB_F01) pbf01_q <= wr_byte;
            if (wr_ix == vdsc_pkg::IDX_PB_F23) pbf23_q <= wr_byte;
            if (wr_ix == vdsc_pkg::IDX_PB_CROP) crop_q <= wr_byte;
        end
    end

    // Read path
    logic [7:0] rd_ix;
    logic [1:0] rd_ch;
    logic [4:0] rd_slot;
    logic [7:0] rd_byte;
    logic       rd_ok;
    assign rd_ix   = idx_of(s_axi_araddr);
    assign rd_ch   = s_axi_araddr[9:8];
    assign rd_slot = 5'(rd_ix - vdsc_pkg::IDX_PEAK);

    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
        if (s_axi_araddr[11:10] == 2'b00) begin
            if (in_chan(s_axi_araddr)) begin
                rd_byte = regs_q[rd_ch][rd_slot];
                rd_ok   = 1'b1;
            end else if (rd_ch == 2'b00 && s_axi_araddr[1:0] == 2'b00) begin
                rd_ok = 1'b1;
                case (rd_ix)
                    vdsc_pkg::IDX_PB_F01:  rd_byte = pbf01_q;
                    vdsc_pkg::IDX_PB_F23:  rd_byte = pbf23_q;
                    vdsc_pkg::IDX_PB_CROP: rd_byte = crop_q;
                    default:               rd_ok   = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Effective settings. Path index 2*c is display, 2*c+1 is record.
    for (genvar c = 0; c < 4; c++) begin : g_cfg
        logic [7:0] r_peak, r_aaf, r_bl, r_pbctl;
        logic [7:0] r_trap [2];
        logic [7:0] r_vf   [2];
        logic [15:0] vr [2];
        logic [15:0] hr [2];
        logic        own_sync, own_filt;
        logic [1:0]  pb_v, pb_h;
        assign r_peak   = regs_q[c][0];
        assign r_aaf    = regs_q[c][1];
        assign r_trap[0] = regs_q[c][2];
        assign r_trap[1] = regs_q[c][3];
        assign vr[0]    = {regs_q[c][4], regs_q[c][5]};
        assign vr[1]    = {regs_q[c][6], regs_q[c][7]};
        assign hr[0]    = {regs_q[c][8], regs_q[c][9]};
        assign hr[1]    = {regs_q[c][10], regs_q[c][11]};
        assign r_vf[0]  = regs_q[c][12];
        assign r_vf[1]  = regs_q[c][13];
        assign r_bl     = regs_q[c][14];
        assign r_pbctl  = regs_q[c][18];
        for (genvar p = 0; p < 2; p++) begin : g_path
            assign path_cfg[2*c+p] = '{
                peak_gain:   p ? r_peak[7:6] : r_peak[5:4],
                peak_band:   p ? r_peak[3] : r_peak[2],
                vert_aa:     p ? r_aaf[7:6] : r_aaf[5:4],
                horiz_aa:    p ? r_aaf[3:2] : r_aaf[1:0],
                trap_wide:   r_trap[p][7],
                // Code 3 is unsupported; treated as adaptive
                comb_force_trap: (r_trap[p][6:5] == 2'b10),
                frame_cif_horiz_filter: r_trap[p][4],
                vert_ratio:  vr[p],
                horiz_ratio: hr[p],
                vert_band_reduction_on: r_vf[p][6],
                vert_band_reduction: r_vf[p][6] ? r_vf[p][5:4] : 2'b00,
                odd_en:      r_vf[p][2],
                even_en:     r_vf[p][1]
            };
            // Gate valid for whole fields whose enable is clear
            assign valid_out[2*c+p] = valid_raw[2*c+p] &&
                                      (field_even[c] ? r_vf[p][1] : r_vf[p][2]);
        end
        assign out_cfg[c].blank_on     = r_bl[7];
        assign out_cfg[c].blank_black  = r_bl[6];
        assign out_cfg[c].range_narrow = r_bl[4];
        assign out_cfg[c].range_min    = r_bl[4] ? vdsc_pkg::RANGE_NARROW_MIN : vdsc_pkg::RANGE_WIDE_MIN;
        assign out_cfg[c].range_max    = r_bl[4] ? vdsc_pkg::RANGE_NARROW_MAX : vdsc_pkg::RANGE_WIDE_MAX;
        assign own_filt = r_pbctl[7];
        assign own_sync = r_pbctl[6];
        assign pb_cfg[c].hstart = own_sync ? {r_pbctl[1:0], regs_q[c][16]} : dec_hstart[10*c +: 10];
        assign pb_cfg[c].hsize  = own_sync ? {r_pbctl[3:2], regs_q[c][17]} : dec_hsize[10*c +: 10];
        assign pb_cfg[c].vstart = own_sync ? {r_pbctl[4], regs_q[c][19]} : dec_vstart[9*c +: 9];
        assign pb_cfg[c].vsize  = own_sync ? {r_pbctl[5], regs_q[c][20]} : dec_vsize[9*c +: 9];
        assign pb_v = (c < 2) ? pbf01_q[4*(c%2)+2 +: 2] : pbf23_q[4*(c%2)+2 +: 2];
        assign pb_h = (c < 2) ? pbf01_q[4*(c%2) +: 2] : pbf23_q[4*(c%2) +: 2];
        assign pb_cfg[c].vert_aa  = own_filt ? pb_v : r_aaf[5:4];
        assign pb_cfg[c].horiz_aa = own_filt ? pb_h : r_aaf[1:0];
    end
endmodule // vdsc_top

// ---- vdsc_top_asserts.sv ----
// Checker: bus handshakes and output relations.
// Sees only vdsc_top ports; bound below.
`timescale 1ns/1ns
module vdsc_asserts (
    // Clock and reset
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // AXI4-Lite handshakes
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    // Video side
    input wire logic [3:0]                  field_even,
    input wire logic [7:0]                  valid_raw,
    input wire vdsc_pkg::vdsc_path_s [7:0]  path_cfg,
    input wire vdsc_pkg::vdsc_out_s  [3:0]  out_cfg,
    input wire logic [7:0]                  valid_out,
    input wire logic [3:0]                  video_reset
);
    logic [7:0] gate_exp;

    // Path 2c+p gated by channel c field
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            gate_exp[p] = valid_raw[p] & (field_even[p / 2] ? path_cfg[p].even_en : path_cfg[p].odd_en);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_field_gate: assert property (valid_out == gate_exp) else $error("field gate");
    a_range_narrow: assert property (out_cfg[2].range_narrow |->
        out_cfg[2].range_min == 8'h10 && out_cfg[2].range_max == 8'hef) else $error("narrow range");
    a_range_wide: assert property (!out_cfg[0].range_narrow |->
        out_cfg[0].range_min == 8'h02 && out_cfg[0].range_max == 8'hfe) else $error("wide range");
    a_reset_defaults: assert property ($rose(aresetn) |-> path_cfg[0].vert_ratio == 16'hffff
        && path_cfg[7].horiz_ratio == 16'hffff && path_cfg[5].odd_en && path_cfg[5].even_en)
        else $error("reset defaults");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("late bvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rvalid dropped");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write during bvalid");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read during rvalid");
    a_soft_len: assert property ($rose(video_reset[0]) |-> video_reset[0][*8] ##1 !video_reset[0])
        else $error("soft reset length");

    c_slow_bresp: cover property (s_axi_bvalid && !s_axi_bready);
    c_read_error: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    c_soft_reset: cover property ($rose(video_reset[0]));
endmodule // vdsc_asserts

bind vdsc_top vdsc_asserts chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .field_even, .valid_raw,
    .path_cfg, .out_cfg, .valid_out, .video_reset
);

// ---- video_decoder_scaler_config_test.sv ----
// Self-checking bench for the bank over AXI4-Lite.
// Assumes pkg, design and checker compiled first.
`timescale 1ns/1ns
module video_decoder_scaler_config_test;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
        logic [1:0]  r;
    } vdsc_row_s;

    logic                       aclk = 1'b0;
    logic                       aresetn = 1'b0;
    logic [11:0]                s_axi_awaddr = 12'h000;
    logic [11:0]                s_axi_araddr = 12'h000;
    logic [31:0]                s_axi_wdata = 32'h0;
    logic [3:0]                 s_axi_wstrb = 4'h1;
    logic                       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]                 s_axi_bresp, s_axi_rresp;
    logic [31:0]                s_axi_rdata;
    logic [39:0]                dec_hstart = {10'h103, 10'h102, 10'h101, 10'h100};
    logic [39:0]                dec_hsize = {10'h2d3, 10'h2d2, 10'h2d1, 10'h2d0};
    logic [35:0]                dec_vstart = {9'h013, 9'h012, 9'h011, 9'h010};
    logic [35:0]                dec_vsize = {9'h0f3, 9'h0f2, 9'h0f1, 9'h0f0};
    logic [3:0]                 field_even = 4'h0;
    logic [7:0]                 valid_raw = 8'hff;
    vdsc_pkg::vdsc_path_s [7:0] path_cfg;
    vdsc_pkg::vdsc_out_s [3:0]  out_cfg;
    vdsc_pkg::vdsc_pb_s [3:0]   pb_cfg;
    logic [7:0]                 valid_out;
    logic [3:0]                 video_reset;
    int                         failures = 0;
    int                         check_count = 0;
    int                         cycles = 0;
    int                         srst_cycles = 0;

    // Address = channel * 0x100 + index * 4
    vdsc_row_s rows[20] = '{
        '{12'h050, 8'h9c, 8'h9c, 2'h0}, '{12'h154, 8'he4, 8'he4, 2'h0},
        '{12'h258, 8'hd0, 8'hd0, 2'h0}, '{12'h35c, 8'h70, 8'h70, 2'h0},
        '{12'h060, 8'h12, 8'h12, 2'h0}, '{12'h064, 8'h34, 8'h34, 2'h0},
        '{12'h078, 8'hab, 8'hab, 2'h0}, '{12'h07c, 8'hcd, 8'hcd, 2'h0},
        '{12'h180, 8'h74, 8'h74, 2'h0}, '{12'h288, 8'hd0, 8'hd0, 2'h0},
        '{12'h18c, 8'h11, 8'h11, 2'h0}, '{12'h398, 8'hc6, 8'hc6, 2'h0},
        '{12'h390, 8'h21, 8'h21, 2'h0}, '{12'h394, 8'h40, 8'h40, 2'h0},
        '{12'h39c, 8'h05, 8'h05, 2'h0}, '{12'h3a0, 8'h60, 8'h60, 2'h0},
        '{12'h0d8, 8'h1b, 8'h1b, 2'h0}, '{12'h0dc, 8'he4, 8'he4, 2'h0},
        '{12'h1d8, 8'h5a, 8'h00, 2'h2}, '{12'h850, 8'h5a, 8'h00, 2'h2}
    };
    vdsc_row_s dflt[11] = '{
        '{12'h050, 8'h00, 8'h00, 2'h0}, '{12'h060, 8'h00, 8'hff, 2'h0}, '{12'h07c, 8'h00, 8'hff, 2'h0},
        '{12'h180, 8'h00, 8'h06, 2'h0}, '{12'h18c, 8'h00, 8'h11, 2'h0}, '{12'h394, 8'h00, 8'hd0, 2'h0},
        '{12'h398, 8'h00, 8'h08, 2'h0}, '{12'h3a0, 8'h00, 8'hf0, 2'h0}, '{12'h390, 8'h00, 8'h00, 2'h0},
        '{12'h288, 8'h00, 8'h00, 2'h0}, '{12'h0dc, 8'h00, 8'h00, 2'h0}
    };

    vdsc_top dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .dec_hstart, .dec_hsize, .dec_vstart, .dec_vsize, .field_even, .valid_raw, .path_cfg,
        .out_cfg, .pb_cfg, .valid_out, .video_reset
    );

    initial begin
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (video_reset[0] === 1'b1) srst_cycles <= srst_cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: response %h, expected %h", $time, got, exp);
        end
    endtask

    // Slow cases keep ready low for dly cycles after the answer shows
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er, input int dly);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= {dly[0], dly[0], dly[0], 1'b1};
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (dly == 0);
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        if (dly > 0) begin
            repeat (dly) @(posedge aclk);
            s_axi_bready <= 1'b1;
            @(posedge aclk);
        end
        chk_r(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er, input int dly);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (dly == 0);
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        if (dly > 0) begin
            repeat (dly) @(posedge aclk);
            s_axi_rready <= 1'b1;
            @(posedge aclk);
        end
        chk_d(s_axi_rdata, {24'h0, e});
        chk_r(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].r, i % 3);
            rd(rows[i].a, rows[i].e, rows[i].r, (i + 1) % 3);
        end
        chk_d(32'({path_cfg[0].peak_gain, path_cfg[1].peak_gain, path_cfg[0].peak_band, path_cfg[1].peak_band}),
              32'h1b);
        chk_d(32'({path_cfg[2].vert_aa, path_cfg[3].vert_aa}), 32'hb);
        chk_d(32'({path_cfg[2].horiz_aa, path_cfg[3].horiz_aa}), 32'h1);
        chk_d(32'({path_cfg[4].trap_wide, path_cfg[7].trap_wide}), 32'h2);
        chk_d(32'({path_cfg[4].comb_force_trap, path_cfg[7].comb_force_trap}), 32'h2);
        chk_d(32'({path_cfg[4].frame_cif_horiz_filter, path_cfg[7].frame_cif_horiz_filter}), 32'h3);
        chk_d({path_cfg[0].vert_ratio, path_cfg[1].vert_ratio}, 32'h1234ffff);
        chk_d({path_cfg[1].horiz_ratio, path_cfg[0].horiz_ratio}, 32'habcdffff);
        chk_d(32'({path_cfg[2].vert_band_reduction_on, path_cfg[2].vert_band_reduction}), 32'h7);
        chk_d(32'({out_cfg[2].blank_on, out_cfg[2].blank_black, out_cfg[0].blank_on}), 32'h6);
        chk_d({out_cfg[2].range_min, out_cfg[2].range_max, out_cfg[0].range_min, out_cfg[0].range_max},
              32'h10ef02fe);
        chk_d(32'({pb_cfg[3].hstart, pb_cfg[3].hsize}), 32'({10'h221, 10'h140}));
        chk_d(32'({pb_cfg[3].vstart, pb_cfg[3].vsize}), 32'({9'h005, 9'h060}));
        chk_d(32'({pb_cfg[1].hstart, pb_cfg[1].hsize}), 32'({10'h101, 10'h2d1}));
        chk_d(32'({pb_cfg[1].vstart, pb_cfg[1].vsize}), 32'({9'h011, 9'h0f1}));
        chk_d(32'({pb_cfg[3].vert_aa, pb_cfg[3].horiz_aa, pb_cfg[1].vert_aa, pb_cfg[1].horiz_aa,
              pb_cfg[0].vert_aa, pb_cfg[0].horiz_aa}), 32'he80);
        // Ch1 display path: even field off
        chk_d(32'(valid_out), 32'hff);
        field_even <= 4'h2;
        valid_raw  <= 8'h7f;
        @(posedge aclk);
        chk_d(32'(valid_out), 32'h7b);
        wr(12'h088, 8'h08, 2'h0, 0);
        repeat (14) @(posedge aclk);
        chk_d(32'(srst_cycles), 32'd8);
        rd(12'h088, 8'h00, 2'h0, 0);
        // Mid-run reset restores defaults
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (dflt[i]) begin
            rd(dflt[i].a, dflt[i].e, dflt[i].r, i % 2);
        end
        stop_test();
    end
endmodule // video_decoder_scaler_config_test
